// File: dtp_params.svh
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH

// Register byte offsets
`define DTP_OFF_UMODE     8'h00
`define DTP_OFF_UVAL      8'h04
`define DTP_OFF_PWR       8'h08
`define DTP_OFF_IRQ_EN    8'h0C
`define DTP_OFF_IRQ_FLAG  8'h10
`define DTP_OFF_DCTRL_A   8'h14
`define DTP_OFF_DCTRL_B   8'h18
`define DTP_OFF_DVAL      8'h1C
`define DTP_OFF_DPS_VAL   8'h20
`define DTP_OFF_DUTY      8'h24
`define DTP_OFF_BUZ       8'h28
`define DTP_OFF_PIN_CFG   8'h2C

// Field positions
`define DTP_BIT_UPCNT_RUN 0
`define DTP_BIT_GIE       7
`define DTP_BIT_UOVF      0
`define DTP_BIT_DUDF      3

// Reset values and byte maximum
`define DTP_RST_UMODE     8'h08
`define DTP_RST_PWR       8'h00
`define DTP_RST_IRQ_EN    8'h00
`define DTP_RST_DCTRL_A   8'h00
`define DTP_RST_DCTRL_B   8'h08
`define DTP_RST_BUZ       8'h00
`define DTP_RST_BYTE      8'h00
`define DTP_MAX_BYTE      8'hFF

`endif

// File: dtp_pkg.sv
`default_nettype none
package dtp_pkg;

	typedef logic [7:0] dtp_byte_t;

	// Up-counter mode register layout
	typedef struct packed {
		logic       upcnt_lowclk_sel;
		logic       rsv6;
		logic       upcnt_src_sel;
		logic       upcnt_edge_sel;
		logic       prescaler_assign;
		logic [2:0] shared_prescale_sel;
	} dtp_upcnt_mode_s;

	// Down-counter first control register layout
	typedef struct packed {
		logic       pwm_out_en;
		logic       pwm_active_low;
		logic [2:0] rsv5_3;
		logic       oneshot_sel;
		logic       reload_sel;
		logic       downcnt_run_en;
	} dtp_downcnt_ctrl_a_s;

	// Down-counter second control register layout
	typedef struct packed {
		logic [1:0] rsv7_6;
		logic       downcnt_src_sel;
		logic       downcnt_edge_sel;
		logic       downcnt_prescale_en_n;
		logic [2:0] downcnt_prescale_sel;
	} dtp_downcnt_ctrl_b_s;

	// Buzzer control register layout
	typedef struct packed {
		logic       buzzer_en;
		logic [2:0] rsv6_4;
		logic [3:0] buzzer_freq_sel;
	} dtp_buzzer_ctrl_s;

	// Shared pin function chosen by the configuration word
	typedef enum logic [1:0] {
		DTP_PIN_PWM    = 2'b01,
		DTP_PIN_BUZZER = 2'b10
	} dtp_pin_fn_e;

endpackage
`default_nettype wire

// File: dtp_timers.sv
// Contract
// - Up-counter advances only while run bit set
// - Write loads up-count, read returns count
// - Source: instruction clock, pin, or low oscillator
// - Edge bit picks falling or rising transitions
// - Prescaler assigned when bit zero, cleared
// - Three-bit select, ratios 1:2 to 1:256
// - Overflow sets sticky flag, interrupt when enabled
// - Down-counter write sets reload and count
// - Down-counter runs only while enable set
// - Down source: pin or instruction clock
// - Down edge bit picks pin transition
// - Active-low prescaler enable, readable prescaler value
// - One-shot counts to zero then stops
// - Continuous restarts from reload or 0xFF
// - Underflow sets sticky flag, interrupt when enabled
// - PWM drives pin when enabled and selected
// - Polarity bit makes PWM active low
// - Duty zero inactive, 0xFF gives 255 clocks
// - Buzzer drives pin when enabled and selected
// - Buzzer top bit picks source, rest ratio
//
// The register offsets and the APB slave port were decided locally.
`include "dtp_params.svh"
`default_nettype none

module dtp_timers
	import dtp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	input  wire logic        ext_clock_pin,
	input  wire logic        low_osc_clk,
	output logic             irq,
	output logic             shared_port_pin_out,
	output logic             shared_port_pin_oe
);

	// Low-order mask of n ones
	function automatic logic [7:0] ones_mask(input logic [3:0] n);
		logic [8:0] m;
		m = (9'h001 << n) - 9'h001;
		return m[7:0];
	endfunction

	// True when counter low bits under mask are all ones
	function automatic logic div_hit(input logic [7:0] cnt, input logic [7:0] mask);
		return (cnt & mask) == mask;
	endfunction

	dtp_upcnt_mode_s     upcnt_mode_reg;
	dtp_byte_t           power_ctrl_reg;
	dtp_byte_t           irq_enable_reg;
	dtp_byte_t           irq_flag_reg;
	dtp_downcnt_ctrl_a_s downcnt_ctrl_a;
	dtp_downcnt_ctrl_b_s downcnt_ctrl_b;
	dtp_buzzer_ctrl_s    buzzer_ctrl_reg;
	dtp_byte_t           pwm_duty_value;
	dtp_pin_fn_e         pin_fn;
	dtp_byte_t           upcnt_value;
	dtp_byte_t           shared_prescale_value;
	dtp_byte_t           downcnt_value;
	dtp_byte_t           downcnt_reload;
	dtp_byte_t           downcnt_prescale_value;
	dtp_byte_t           buzzer_div;
	logic                buzzer_level;
	logic                ext_prev;
	logic                low_prev;

	// Bus decode
	logic           addr_ok;
	logic [31:0]    next_prdata;
	dtp_byte_t      rd_byte;
	wire logic      wr_en = psel & penable & pready & pwrite;
	wire logic      setup = psel & ~penable;
	wire dtp_byte_t wdata = pwdata[7:0];

	function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
		return en & (a == off);
	endfunction

	wire logic wr_umode = wr_hit(wr_en, paddr, `DTP_OFF_UMODE);
	wire logic wr_uval  = wr_hit(wr_en, paddr, `DTP_OFF_UVAL);
	wire logic wr_pwr   = wr_hit(wr_en, paddr, `DTP_OFF_PWR);
	wire logic wr_ien   = wr_hit(wr_en, paddr, `DTP_OFF_IRQ_EN);
	wire logic wr_iflag = wr_hit(wr_en, paddr, `DTP_OFF_IRQ_FLAG);
	wire logic wr_dca   = wr_hit(wr_en, paddr, `DTP_OFF_DCTRL_A);
	wire logic wr_dcb   = wr_hit(wr_en, paddr, `DTP_OFF_DCTRL_B);
	wire logic wr_dval  = wr_hit(wr_en, paddr, `DTP_OFF_DVAL);
	wire logic wr_duty  = wr_hit(wr_en, paddr, `DTP_OFF_DUTY);
	wire logic wr_buz   = wr_hit(wr_en, paddr, `DTP_OFF_BUZ);
	wire logic wr_pin   = wr_hit(wr_en, paddr, `DTP_OFF_PIN_CFG);

	// Read selection
	always_comb begin
		addr_ok = 1'b1;
		rd_byte = `DTP_RST_BYTE;
		if (paddr == `DTP_OFF_UMODE) begin
			rd_byte = upcnt_mode_reg;
		end else if (paddr == `DTP_OFF_UVAL) begin
			rd_byte = upcnt_value;
		end else if (paddr == `DTP_OFF_PWR) begin
			rd_byte = power_ctrl_reg;
		end else if (paddr == `DTP_OFF_IRQ_EN) begin
			rd_byte = irq_enable_reg;
		end else if (paddr == `DTP_OFF_IRQ_FLAG) begin
			rd_byte = irq_flag_reg;
		end else if (paddr == `DTP_OFF_DCTRL_A) begin
			rd_byte = downcnt_ctrl_a;
		end else if (paddr == `DTP_OFF_DCTRL_B) begin
			rd_byte = downcnt_ctrl_b;
		end else if (paddr == `DTP_OFF_DVAL) begin
			rd_byte = downcnt_value;
		end else if (paddr == `DTP_OFF_DPS_VAL) begin
			rd_byte = downcnt_prescale_value;
		end else if (paddr == `DTP_OFF_DUTY) begin
			rd_byte = pwm_duty_value;
		end else if (paddr == `DTP_OFF_BUZ) begin
			rd_byte = buzzer_ctrl_reg;
		end else if (paddr == `DTP_OFF_PIN_CFG) begin
			rd_byte = {7'h00, pin_fn == DTP_PIN_BUZZER};
		end else begin
			addr_ok = 1'b0;
		end
	end

	assign next_prdata = {24'h000000, rd_byte};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~addr_ok;
			prdata  <= (setup & ~pwrite) ? next_prdata : 32'h00000000;
		end
	end

	// Pin edge detection
	wire logic ext_rise = ext_clock_pin & ~ext_prev;
	wire logic ext_fall = ~ext_clock_pin & ext_prev;
	wire logic low_rise = low_osc_clk & ~low_prev;
	wire logic low_fall = ~low_osc_clk & low_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev <= 1'b0;
			low_prev <= 1'b0;
		end else begin
			ext_prev <= ext_clock_pin;
			low_prev <= low_osc_clk;
		end
	end

	// Up-counter path
	logic u_run;
	logic u_pin_rise;
	logic u_pin_fall;
	logic u_src_tick;
	logic u_ps_on;
	logic u_ps_hit;
	logic u_tick;
	logic u_ovf;
	logic u_ps_clr;

	assign u_run      = power_ctrl_reg[`DTP_BIT_UPCNT_RUN];
	assign u_pin_rise = upcnt_mode_reg.upcnt_lowclk_sel ? low_rise : ext_rise;
	assign u_pin_fall = upcnt_mode_reg.upcnt_lowclk_sel ? low_fall : ext_fall;
	assign u_src_tick = ~upcnt_mode_reg.upcnt_src_sel ? 1'b1 :
		(upcnt_mode_reg.upcnt_edge_sel ? u_pin_fall : u_pin_rise);
	assign u_ps_on    = ~upcnt_mode_reg.prescaler_assign;
	assign u_ps_hit   = div_hit(shared_prescale_value, ones_mask({1'b0, upcnt_mode_reg.shared_prescale_sel} + 4'h1));
	assign u_tick     = u_run & u_src_tick & (~u_ps_on | u_ps_hit);
	assign u_ovf      = u_tick & (upcnt_value == `DTP_MAX_BYTE);
	assign u_ps_clr   = wr_umode & ~wdata[3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_prescale_value <= `DTP_RST_BYTE;
		end else if (u_ps_clr) begin
			shared_prescale_value <= `DTP_RST_BYTE;
		end else if (u_run & u_src_tick & u_ps_on) begin
			shared_prescale_value <= shared_prescale_value + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upcnt_value <= `DTP_RST_BYTE;
		end else if (wr_uval) begin
			upcnt_value <= wdata;
		end else if (u_tick) begin
			upcnt_value <= upcnt_value + 8'h01;
		end
	end

	// Down-counter path
	logic d_run;
	logic d_src_tick;
	logic d_ps_on;
	logic d_ps_tick;
	logic d_tick;
	logic d_udf;
	dtp_byte_t next_dval;

	assign d_run      = downcnt_ctrl_a.downcnt_run_en;
	assign d_src_tick = ~downcnt_ctrl_b.downcnt_src_sel ? 1'b1 :
		(downcnt_ctrl_b.downcnt_edge_sel ? ext_fall : ext_rise);
	assign d_ps_on    = ~downcnt_ctrl_b.downcnt_prescale_en_n;
	assign d_ps_tick  = d_run & d_src_tick & (~d_ps_on |
		div_hit(downcnt_prescale_value, ones_mask({1'b0, downcnt_ctrl_b.downcnt_prescale_sel} + 4'h1)));
	assign d_tick     = d_ps_tick;
	assign d_udf      = d_tick & (downcnt_value == `DTP_RST_BYTE);

	always_comb begin
		next_dval = downcnt_value;
		if (wr_dval) begin
			next_dval = wdata;
		end else if (d_udf) begin
			if (downcnt_ctrl_a.oneshot_sel) begin
				next_dval = `DTP_RST_BYTE;
			end else if (downcnt_ctrl_a.reload_sel) begin
				next_dval = downcnt_reload;
			end else begin
				next_dval = `DTP_MAX_BYTE;
			end
		end else if (d_tick) begin
			next_dval = downcnt_value - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			downcnt_prescale_value <= `DTP_RST_BYTE;
		end else if (d_run & d_src_tick & d_ps_on) begin
			downcnt_prescale_value <= downcnt_prescale_value + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			downcnt_value  <= `DTP_RST_BYTE;
			downcnt_reload <= `DTP_RST_BYTE;
		end else begin
			downcnt_value <= next_dval;
			if (wr_dval) begin
				downcnt_reload <= wdata;
			end
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upcnt_mode_reg  <= `DTP_RST_UMODE;
			power_ctrl_reg  <= `DTP_RST_PWR;
			irq_enable_reg  <= `DTP_RST_IRQ_EN;
			downcnt_ctrl_b  <= `DTP_RST_DCTRL_B;
			buzzer_ctrl_reg <= `DTP_RST_BUZ;
			pwm_duty_value  <= `DTP_RST_BYTE;
			pin_fn          <= DTP_PIN_PWM;
		end else begin
			if (wr_umode) upcnt_mode_reg <= wdata & 8'hBF;
			if (wr_pwr) power_ctrl_reg <= wdata & 8'h81;
			if (wr_ien) irq_enable_reg <= wdata & 8'h09;
			if (wr_dcb) downcnt_ctrl_b <= wdata & 8'h3F;
			if (wr_buz) buzzer_ctrl_reg <= wdata & 8'h8F;
			if (wr_duty) pwm_duty_value <= wdata;
			if (wr_pin) pin_fn <= wdata[0] ? DTP_PIN_BUZZER : DTP_PIN_PWM;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			downcnt_ctrl_a <= `DTP_RST_DCTRL_A;
		end else if (wr_dca) begin
			downcnt_ctrl_a <= wdata & 8'hC7;
		end else if (d_udf & downcnt_ctrl_a.oneshot_sel) begin
			downcnt_ctrl_a.downcnt_run_en <= 1'b0;
		end
	end

	// sticky flags, set wins over clear
	wire logic [7:0] flag_set  = {4'h0, d_udf, 2'b00, u_ovf};
	wire logic [7:0] flag_keep = wr_iflag ? (irq_flag_reg & wdata) : irq_flag_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flag_reg <= `DTP_RST_BYTE;
			irq          <= 1'b0;
		end else begin
			irq_flag_reg <= (flag_keep | flag_set) & 8'h09;
			irq          <= power_ctrl_reg[`DTP_BIT_GIE] & |(irq_flag_reg & irq_enable_reg);
		end
	end

	wire logic b_src_tick = buzzer_ctrl_reg.buzzer_freq_sel[3] ? d_udf : d_ps_tick;
	wire logic b_hit      = div_hit(buzzer_div, ones_mask({1'b0, buzzer_ctrl_reg.buzzer_freq_sel[2:0]}));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buzzer_div   <= `DTP_RST_BYTE;
			buzzer_level <= 1'b0;
		end else if (~buzzer_ctrl_reg.buzzer_en) begin
			buzzer_div   <= `DTP_RST_BYTE;
			buzzer_level <= 1'b0;
		end else if (b_src_tick) begin
			buzzer_div <= buzzer_div + 8'h01;
			if (b_hit) begin
				buzzer_level <= ~buzzer_level;
			end
		end
	end

	wire logic pwm_active = d_run & (downcnt_value < pwm_duty_value);
	wire logic pwm_level  = pwm_active ^ downcnt_ctrl_a.pwm_active_low;
	wire logic pwm_drive  = downcnt_ctrl_a.pwm_out_en & (pin_fn == DTP_PIN_PWM);
	wire logic buz_drive  = buzzer_ctrl_reg.buzzer_en & (pin_fn == DTP_PIN_BUZZER);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_port_pin_out <= 1'b0;
			shared_port_pin_oe  <= 1'b0;
		end else begin
			shared_port_pin_oe  <= pwm_drive | buz_drive;
			shared_port_pin_out <= pwm_drive ? pwm_level : (buz_drive & buzzer_level);
		end
	end

endmodule
`default_nettype wire

// File: dtp_timers_checker.sv
`include "dtp_params.svh"
`default_nettype none

module dtp_timers_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        irq,
	input wire logic        shared_port_pin_out,
	input wire logic        shared_port_pin_oe
);
	logic       global_irq_en;
	logic [1:0] ien;
	logic [2:0] ctla;
	logic [7:0] duty;
	logic       buz_en;
	logic       cfg;
	wire logic  wr = psel && penable && pready && pwrite;
	wire logic  drv = (ctla[2] && !cfg) || (buz_en && cfg);
	wire logic  pwm_idle = ctla[2] && !cfg && (duty == 8'h00 || !ctla[0]);

	// Shadow of control bits written over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{global_irq_en, ien, ctla, duty, buz_en, cfg} <= 16'h0000;
		end else if (wr) begin
			case (paddr)
				`DTP_OFF_PWR: global_irq_en <= pwdata[7];
				`DTP_OFF_IRQ_EN: ien <= {pwdata[3], pwdata[0]};
				`DTP_OFF_DCTRL_A: ctla <= {pwdata[7:6], pwdata[0]};
				`DTP_OFF_DUTY: duty <= pwdata[7:0];
				`DTP_OFF_BUZ: buz_en <= pwdata[7];
				`DTP_OFF_PIN_CFG: cfg <= pwdata[0];
				default: ;
			endcase
		end
	end

	a_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready) else $error("pready missing");
	a_refuse_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && paddr > 8'h2C |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
	a_irq_global: assert property (@(posedge pclk) disable iff (!presetn)
		!global_irq_en ##1 !global_irq_en |-> !irq) else $error("irq without global enable");
	a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
		ien == 2'b00 ##1 ien == 2'b00 |-> !irq) else $error("irq while masked");
	a_pin_released: assert property (@(posedge pclk) disable iff (!presetn)
		!drv [*2] |-> !shared_port_pin_oe) else $error("pin driven unselected");
	a_pin_driven: assert property (@(posedge pclk) disable iff (!presetn)
		drv [*2] |-> shared_port_pin_oe) else $error("pin not driven");
	a_pwm_inactive: assert property (@(posedge pclk) disable iff (!presetn)
		pwm_idle [*2] |-> shared_port_pin_out == $past(ctla[1])) else $error("pwm not inactive");
	a_buzzer_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg && !buz_en) [*2] |-> !shared_port_pin_out) else $error("buzzer not quiet");
endmodule

bind dtp_timers dtp_timers_checker chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq),
	.shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe(shared_port_pin_oe)
);
`default_nettype wire

// File: tb_dual_timer_pwm_buzzer.sv
`include "dtp_params.svh"
`default_nettype none

module tb_dual_timer_pwm_buzzer import dtp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        ext_clock_pin = 1'b0;
	logic        low_osc_clk = 1'b0;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        irq;
	logic        pin_out;
	logic        pin_oe;
	logic [31:0] rdat;
	logic [31:0] v;
	logic        rerr;
	logic        p;
	int          n;
	int          hi;
	int          tg;
	int          num_errors = 0;
	int          samples_checked = 0;
	// Address, write flag, write data, expected read
	dtp_byte_t   regs [15][4] = '{'{8'h00, 8'h00, 8'h00, 8'h08}, '{8'h04, 8'h00, 8'h00, 8'h00},
		'{8'h08, 8'h00, 8'h00, 8'h00}, '{8'h0C, 8'h00, 8'h00, 8'h00}, '{8'h10, 8'h00, 8'h00, 8'h00},
		'{8'h14, 8'h00, 8'h00, 8'h00}, '{8'h18, 8'h00, 8'h00, 8'h08}, '{8'h1C, 8'h00, 8'h00, 8'h00},
		'{8'h00, 8'h01, 8'hFF, 8'hBF}, '{8'h0C, 8'h01, 8'hFF, 8'h09}, '{8'h14, 8'h01, 8'hC6, 8'hC6},
		'{8'h18, 8'h01, 8'hFF, 8'h3F}, '{8'h28, 8'h01, 8'hFF, 8'h8F}, '{8'h2C, 8'h01, 8'hFF, 8'h01},
		'{8'h30, 8'h01, 8'hFF, 8'h00}};
	// Up mode, use oscillator, expected count
	dtp_byte_t   edges [4][3] = '{'{8'h28, 8'h00, 8'h05}, '{8'h38, 8'h00, 8'h04},
		'{8'hA8, 8'h01, 8'h05}, '{8'hB8, 8'h01, 8'h04}};
	// Control b, control a, expected count
	dtp_byte_t   downs [3][3] = '{'{8'h28, 8'h01, 8'hFF}, '{8'h28, 8'h03, 8'h02}, '{8'h38, 8'h01, 8'h00}};
	// Pin config, control a, duty, buzzer, high cycles, toggles
	dtp_byte_t   waves [6][6] = '{'{8'h00, 8'h83, 8'h04, 8'h00, 8'h50, 8'h28},
		'{8'h00, 8'hC3, 8'h04, 8'h00, 8'h78, 8'h28}, '{8'h00, 8'h83, 8'h00, 8'h00, 8'h00, 8'h00},
		'{8'h01, 8'h03, 8'h00, 8'h88, 8'h64, 8'h14}, '{8'h01, 8'h03, 8'h00, 8'h82, 8'h64, 8'h32},
		'{8'h01, 8'h83, 8'h04, 8'h00, 8'h00, 8'h00}};

	`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
		$display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end

	always #2 pclk = ~pclk;

	dtp_timers dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .ext_clock_pin(ext_clock_pin),
		.low_osc_clk(low_osc_clk), .irq(irq), .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe)
	);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic apb(input dtp_byte_t a, input logic w, input dtp_byte_t d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 9);
		if (pready !== 1'b1) begin
			num_errors++;
			report_and_stop();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input dtp_byte_t a);
		apb(a, 1'b0, 8'h00);
	endtask

	task automatic rows(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			if (regs[i][1][0]) begin
				apb(regs[i][0], 1'b1, regs[i][2]);
			end
			rd(regs[i][0]);
			`CHK(rdat, {24'h0, regs[i][3]})
			`CHK(rerr, regs[i][0] > 8'h2C)
		end
	endtask

	// Rising edges n times, falling edges n-1 times
	task automatic pulses(input int cnt, input logic osc);
		for (int i = 0; i < cnt; i++) begin
			@(posedge pclk);
			ext_clock_pin <= !osc;
			low_osc_clk <= osc;
			repeat (2) @(posedge pclk);
			if (i < cnt - 1) begin
				ext_clock_pin <= 1'b0;
				low_osc_clk <= 1'b0;
			end
			@(posedge pclk);
		end
	endtask

	task automatic stop_pins(input dtp_byte_t a);
		apb(a, 1'b1, 8'h00);
		ext_clock_pin <= 1'b0;
		low_osc_clk <= 1'b0;
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		num_errors++;
		report_and_stop();
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rows(15);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rows(8);
		$display("register test done");
		apb(8'h04, 1'b1, 8'hFC);
		apb(8'h0C, 1'b1, 8'h01);
		apb(8'h08, 1'b1, 8'h81);
		n = 0;
		while (irq !== 1'b1 && n < 50) begin
			@(negedge pclk);
			n++;
		end
		`CHK(irq, 1'b1)
		apb(8'h08, 1'b1, 8'h80);
		rd(8'h10);
		`CHK(rdat[7:0], 8'h01)
		rd(8'h04);
		v = rdat;
		repeat (5) @(posedge pclk);
		rd(8'h04);
		`CHK(rdat, v)
		apb(8'h10, 1'b1, 8'h00);
		rd(8'h10);
		`CHK(rdat[7:0], 8'h00)
		`CHK(irq, 1'b0)
		for (int i = 0; i < 2; i++) begin
			apb(8'h04, 1'b1, 8'h00);
			apb(8'h00, 1'b1, i ? 8'h02 : 8'h07);
			apb(8'h08, 1'b1, 8'h01);
			repeat (i ? 40 : 600) @(posedge pclk);
			apb(8'h08, 1'b1, 8'h00);
			rd(8'h04);
			`CHK(rdat[7:0], i ? 8'h05 : 8'h02)
		end
		for (int i = 0; i < 4; i++) begin
			apb(8'h04, 1'b1, 8'h00);
			apb(8'h00, 1'b1, edges[i][0]);
			apb(8'h08, 1'b1, 8'h01);
			pulses(5, edges[i][1][0]);
			stop_pins(8'h08);
			rd(8'h04);
			`CHK(rdat[7:0], edges[i][2])
		end
		apb(8'h04, 1'b1, 8'h00);
		apb(8'h00, 1'b1, 8'hA2);
		apb(8'h08, 1'b1, 8'h01);
		pulses(16, 1'b1);
		stop_pins(8'h08);
		rd(8'h04);
		`CHK(rdat[7:0], 8'h02)
		$display("up counter test done");
		for (int i = 0; i < 3; i++) begin
			apb(8'h1C, 1'b1, 8'h02);
			apb(8'h18, 1'b1, downs[i][0]);
			apb(8'h14, 1'b1, downs[i][1]);
			pulses(3, 1'b0);
			stop_pins(8'h14);
			rd(8'h1C);
			`CHK(rdat[7:0], downs[i][2])
		end
		apb(8'h1C, 1'b1, 8'h10);
		apb(8'h18, 1'b1, 8'h00);
		apb(8'h14, 1'b1, 8'h01);
		repeat (10) @(posedge pclk);
		apb(8'h14, 1'b1, 8'h00);
		rd(8'h20);
		`CHK(rdat[7:0], 8'h0D)
		rd(8'h1C);
		`CHK(rdat[7:0], 8'h0A)
		apb(8'h08, 1'b1, 8'h80);
		apb(8'h10, 1'b1, 8'h00);
		apb(8'h0C, 1'b1, 8'h08);
		apb(8'h18, 1'b1, 8'h08);
		apb(8'h1C, 1'b1, 8'h05);
		apb(8'h14, 1'b1, 8'h05);
		repeat (20) @(posedge pclk);
		rd(8'h1C);
		`CHK(rdat[7:0], 8'h00)
		rd(8'h14);
		`CHK(rdat[7:0], 8'h04)
		rd(8'h10);
		`CHK(rdat[7:0], 8'h08)
		`CHK(irq, 1'b1)
		$display("down counter test done");
		apb(8'h1C, 1'b1, 8'h09);
		for (int i = 0; i < 6; i++) begin
			apb(8'h28, 1'b1, waves[i][3]);
			apb(8'h24, 1'b1, waves[i][2]);
			apb(8'h2C, 1'b1, waves[i][0]);
			apb(8'h14, 1'b1, waves[i][1]);
			repeat (50) @(negedge pclk);
			hi = 0;
			tg = 0;
			p = pin_out;
			repeat (200) begin
				@(negedge pclk);
				hi += int'(pin_out);
				tg += int'(pin_out != p);
				p = pin_out;
			end
			`CHK(8'(hi), waves[i][4])
			`CHK(8'(tg), waves[i][5])
			`CHK(pin_oe, waves[i][0][0] ? waves[i][3][7] : waves[i][1][7])
		end
		$display("pin output test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
